// ===== hw/psc_phase_ctl.sv
// phase step counter control: switches, count, shifter drive, range lamp, apb registers
// Notes on behaviour
// RULE1: phase count lives in two cascaded presettable four-bit up/down counters.
// RULE2: after reset the count is preset from the 16-position selector.
// RULE3: oscillator runs only in operate mode; one step per period while switch held.
// RULE4: the adjust switch position chooses count up or count down.
// RULE5: shifter a gets the count, shifter b its bitwise inverse.
// RULE6: each shifter sees the same six-bit word on both line groups.
// RULE7: a high line turns its diode on; all high means maximum capacitance.
// RULE8: range lamp lights while a step beyond reach is requested; lit here only in operate mode, not in standby.
// RULE9: switches are debounced by a filter and a hysteresis threshold.
// RULE10: at minimum or maximum the count holds instead of wrapping, lamp lit.
//
// The placing of the registers and the APB register port are this design's own decisions.
`include "psc_consts.svh"
`default_nettype none
module psc_phase_ctl
    import psc_pkg::*;
#(
    parameter int unsigned STEP_CYC = `PSC_STEP_CYC,
    parameter int unsigned DB_CYC = `PSC_DB_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // front panel
    input wire logic adjust_up_i,
    input wire logic adjust_down_i,
    input wire logic [3:0] preset_selector_i,
    output logic range_limit_indicator_o,
    // shifter drive lines
    output psc_shifter_t shifter_a_o,
    output psc_shifter_t shifter_b_o,
    // interrupt
    output logic irq_o
);
    localparam int unsigned OW = $clog2(STEP_CYC);
    localparam logic [OW-1:0] OSC_LAST = OW'(STEP_CYC - 1);

    psc_apb_req_t req;
    psc_init_t init_ff;
    psc_init_t nxt_init;
    logic [1:0] init_cnt_ff;
    logic [3:0] sel1_ff;
    logic [3:0] sel2_ff;
    logic up_lvl;
    logic dn_lvl;
    logic req_up;
    logic req_dn;
    logic operate_ff;
    logic [OW-1:0] osc_ff;
    logic running;
    logic tick;
    logic [7:0] count;
    logic at_max;
    logic at_min;
    logic blocked;
    logic step;
    logic limit_evt;
    logic load;
    logic low_carry;
    logic range_ff;
    psc_shifter_t drv_a_ff;
    psc_shifter_t drv_b_ff;
    logic [1:0] int_stat_ff;
    logic [1:0] int_mask_ff;
    logic [1:0] nxt_int_stat;
    logic [1:0] nxt_int_mask;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic hit_ctrl;
    logic hit_status;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic wr_en;
    logic setup;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    // switch debounce, one per contact of the adjust switch
    psc_debounce #(.DB_CYC(DB_CYC)) u_db_up (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(adjust_up_i),
        .level_o(up_lvl)
    );
    psc_debounce #(.DB_CYC(DB_CYC)) u_db_dn (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(adjust_down_i),
        .level_o(dn_lvl)
    );

    // both contacts at once cannot happen on a real toggle; treat it as no request
    assign req_up = up_lvl & ~dn_lvl; // RULE4
    assign req_dn = dn_lvl & ~up_lvl; // RULE4

    // power-up preset sequence: wait for the selector synchroniser, then load once
    always_comb begin
        unique case (init_ff)
            PSC_INIT_WAIT: nxt_init = (init_cnt_ff == `PSC_INIT_CYC) ? PSC_INIT_LOAD : PSC_INIT_WAIT;
            PSC_INIT_LOAD: nxt_init = PSC_INIT_RUN;
            PSC_INIT_RUN: nxt_init = PSC_INIT_RUN;
            default: nxt_init = PSC_INIT_WAIT;
        endcase
    end
    assign load = (init_ff == PSC_INIT_LOAD); // RULE2

    // count oscillator
    assign running = operate_ff & (init_ff == PSC_INIT_RUN); // RULE3
    assign tick = running & (osc_ff == OSC_LAST); // RULE3

    assign at_max = (count == `PSC_CNT_MAX);
    assign at_min = (count == `PSC_CNT_MIN);
    assign blocked = (req_up & at_max) | (req_dn & at_min); // RULE10
    assign step = tick & (req_up | req_dn) & ~blocked; // RULE3
    assign limit_evt = tick & blocked; // RULE10

    psc_nibble_counter u_phase_counter_low (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load),
        .load_val_i({sel2_ff[1:0], 2'b00}),
        .en_i(step),
        .up_i(req_up),
        .q_o(count[3:0]),
        .carry_o(low_carry)
    );
    psc_nibble_counter u_phase_counter_high (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load),
        .load_val_i({2'b00, sel2_ff[3:2]}),
        .en_i(low_carry),
        .up_i(req_up),
        .q_o(count[7:4]),
        .carry_o()
    );

    // apb decode; zero wait states
    assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};
    assign hit_ctrl = (req.paddr == `PSC_ADDR_CTRL);
    assign hit_status = (req.paddr == `PSC_ADDR_STATUS);
    assign hit_stat = (req.paddr == `PSC_ADDR_INT_STAT);
    assign hit_mask = (req.paddr == `PSC_ADDR_INT_MASK);
    assign mapped = hit_ctrl | hit_status | hit_stat | hit_mask;
    assign setup = req.psel & ~req.penable;
    assign wr_en = req.psel & req.penable & req.pwrite & mapped;
    assign status_word = {20'h00000, operate_ff, req_dn, req_up, range_ff, count};
    assign rd_mux = hit_ctrl ? {31'h0, operate_ff} :
                    hit_status ? status_word :
                    hit_stat ? {30'h0, int_stat_ff} :
                    hit_mask ? {30'h0, int_mask_ff} : 32'h00000000;
    assign pready_o = 1'b1;
    assign pslverr_o = req.psel & req.penable & ~mapped;
    assign prdata_o = prdata_ff;

    // a new event wins over a write-one-to-clear in the same cycle
    assign nxt_int_stat = (int_stat_ff & ~((wr_en & hit_stat) ? req.pwdata[1:0] : 2'b00)) | {limit_evt, step};
    // irq built from next flags and next mask so it never lags a mask write
    assign nxt_int_mask = (wr_en & hit_mask) ? req.pwdata[1:0] : int_mask_ff;

    assign shifter_a_o = drv_a_ff;
    assign shifter_b_o = drv_b_ff;
    assign range_limit_indicator_o = range_ff;
    assign irq_o = irq_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_ff <= PSC_INIT_WAIT;
            init_cnt_ff <= 2'd0;
            sel1_ff <= 4'h0;
            sel2_ff <= 4'h0;
        end else begin
            init_ff <= nxt_init;
            init_cnt_ff <= (init_ff == PSC_INIT_WAIT) ? init_cnt_ff + 2'd1 : init_cnt_ff;
            sel1_ff <= preset_selector_i;
            sel2_ff <= sel1_ff;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_ff <= '0;
        end else begin
            osc_ff <= (!running || tick) ? '0 : osc_ff + OW'(1); // RULE3
        end
    end

    // drive lines registered; high line = diode on = capacitor added
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            drv_a_ff <= '0;
            drv_b_ff <= '1;
            range_ff <= 1'b0;
        end else begin
            drv_a_ff <= '{grp_hi: count[5:0], grp_lo: count[5:0]}; // RULE5 RULE6 RULE7
            drv_b_ff <= '{grp_hi: ~count[5:0], grp_lo: ~count[5:0]}; // RULE5 RULE6
            range_ff <= running & blocked; // RULE8
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            operate_ff <= `PSC_CTRL_RST;
            int_stat_ff <= 2'b00;
            int_mask_ff <= `PSC_INT_MASK_RST;
            irq_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            operate_ff <= (wr_en & hit_ctrl) ? req.pwdata[`PSC_CTRL_OPERATE_BIT] : operate_ff;
            int_mask_ff <= nxt_int_mask;
            int_stat_ff <= nxt_int_stat;
            irq_ff <= |(nxt_int_stat & nxt_int_mask);
            prdata_ff <= (setup & ~req.pwrite) ? rd_mux : prdata_ff;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_cascade_up;
        step && req_up |=> count == $past(count) + 8'h01;
    endproperty
    a_cascade_up: assert property (p_cascade_up) else $error("count did not step up by one"); // RULE1

    property p_preset;
        load |=> count == {2'b00, $past(sel2_ff), 2'b00};
    endproperty
    a_preset: assert property (p_preset) else $error("count not preset from selector"); // RULE2

    property p_step_gate;
        step |-> operate_ff && osc_ff == OSC_LAST && (req_up || req_dn);
    endproperty
    a_step_gate: assert property (p_step_gate) else $error("step outside an operate period"); // RULE3

    property p_down;
        step && req_dn |=> count == $past(count) - 8'h01;
    endproperty
    a_down: assert property (p_down) else $error("count did not step down by one"); // RULE4

    property p_inverse;
        ##1 1'b1 |-> shifter_b_o.grp_lo == ~shifter_a_o.grp_lo;
    endproperty
    a_inverse: assert property (p_inverse) else $error("second shifter not the inverse"); // RULE5

    property p_groups;
        shifter_a_o.grp_hi == shifter_a_o.grp_lo && shifter_b_o.grp_hi == shifter_b_o.grp_lo;
    endproperty
    a_groups: assert property (p_groups) else $error("line groups differ"); // RULE6

    property p_polarity;
        ##1 1'b1 |-> shifter_a_o.grp_lo == $past(count[5:0]);
    endproperty
    a_polarity: assert property (p_polarity) else $error("drive word does not follow count"); // RULE7

    property p_lamp;
        running && blocked |=> range_limit_indicator_o;
    endproperty
    a_lamp: assert property (p_lamp) else $error("range lamp not lit at limit"); // RULE8

    property p_hold;
        limit_evt |=> count == $past(count) && int_stat_ff[`PSC_INT_LIMIT_BIT];
    endproperty
    a_hold: assert property (p_hold) else $error("count moved at limit"); // RULE10

    property p_cap;
        count <= `PSC_CNT_MAX;
    endproperty
    a_cap: assert property (p_cap) else $error("count beyond shifter range"); // RULE10

    property p_step_flag;
        step |=> int_stat_ff[`PSC_INT_STEP_BIT];
    endproperty
    a_step_flag: assert property (p_step_flag) else $error("step event not recorded"); // RULE3

    property p_w1c;
        wr_en && hit_stat && req.pwdata[`PSC_INT_STEP_BIT] && !step |=> !int_stat_ff[`PSC_INT_STEP_BIT];
    endproperty
    a_w1c: assert property (p_w1c) else $error("step flag not cleared by write");

    property p_irq_level;
        irq_o == |(int_stat_ff & int_mask_ff);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt line disagrees with flags");

    property p_osc_stop;
        !running |=> osc_ff == '0 && !tick;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran outside operate mode"); // RULE3

    property p_lamp_off;
        !(running && blocked) |=> !range_limit_indicator_o;
    endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("range lamp lit without a blocked request"); // RULE8

    c_step_up: cover property (step && req_up);
    c_step_dn: cover property (step && req_dn);
    c_limit: cover property (limit_evt);
    c_irq: cover property ($rose(irq_o));
endmodule // psc_phase_ctl
`default_nettype wire

// ===== hw/psc_consts.svh
// constants for the phase step counter control block
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// apb register byte offsets
`define PSC_ADDR_CTRL 8'h00
`define PSC_ADDR_STATUS 8'h04
`define PSC_ADDR_INT_STAT 8'h08
`define PSC_ADDR_INT_MASK 8'h0c

// ctrl fields and reset value
`define PSC_CTRL_OPERATE_BIT 0
`define PSC_CTRL_RST 1'b1

// status fields
`define PSC_STAT_COUNT_LSB 0
`define PSC_STAT_RANGE_BIT 8
`define PSC_STAT_UP_BIT 9
`define PSC_STAT_DOWN_BIT 10
`define PSC_STAT_OPERATE_BIT 11

// interrupt status and mask fields
`define PSC_INT_STEP_BIT 0
`define PSC_INT_LIMIT_BIT 1
`define PSC_INT_MASK_RST 2'b00

// count range reachable by the six-line shifter word
`define PSC_CNT_MIN 8'h00
`define PSC_CNT_MAX 8'h3f
`define PSC_CNT_RST 8'h00

// timing
`define PSC_CLK_HZ 20000000
`define PSC_STEP_MS 100
`define PSC_STEP_CYC ((`PSC_CLK_HZ / 1000) * `PSC_STEP_MS)
`define PSC_DB_MS 10
`define PSC_DB_CYC ((`PSC_CLK_HZ / 1000) * `PSC_DB_MS)
`define PSC_INIT_CYC 2'd3

`endif

// ===== hw/psc_pkg.sv
// types for the phase step counter control block
`default_nettype none
package psc_pkg;
    // six-line control word, presented twice per shifter
    typedef struct packed {
        logic [5:0] grp_hi;
        logic [5:0] grp_lo;
    } psc_shifter_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } psc_apb_req_t;

    typedef enum logic [1:0] {
        PSC_INIT_WAIT = 2'b00,
        PSC_INIT_LOAD = 2'b01,
        PSC_INIT_RUN = 2'b10
    } psc_init_t;
endpackage
`default_nettype wire

// ===== hw/psc_nibble_counter.sv
// presettable four-bit up/down counter stage with cascade carry
`default_nettype none
module psc_nibble_counter (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic load_i,
    input wire logic [3:0] load_val_i,
    input wire logic en_i,
    input wire logic up_i,
    // state
    output logic [3:0] q_o,
    output logic carry_o
);
    logic [3:0] q_ff;
    logic [3:0] nxt_q;

    assign nxt_q = load_i ? load_val_i : (en_i ? (up_i ? q_ff + 4'h1 : q_ff - 4'h1) : q_ff); // RULE1
    assign carry_o = en_i & (up_i ? (q_ff == 4'hf) : (q_ff == 4'h0)); // RULE1
    assign q_o = q_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_ff <= 4'h0;
        end else begin
            q_ff <= nxt_q;
        end
    end
endmodule // psc_nibble_counter
`default_nettype wire

// ===== hw/psc_debounce.sv
// switch debouncer: synchroniser, integrating filter, hysteresis threshold
`include "psc_consts.svh"
`default_nettype none
module psc_debounce #(
    parameter int unsigned DB_CYC = `PSC_DB_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw switch and clean level
    input wire logic pin_i,
    output logic level_o
);
    localparam int unsigned W = $clog2(DB_CYC + 1);
    localparam logic [W-1:0] TOP = W'(DB_CYC);
    localparam logic [W-1:0] HI = W'((DB_CYC * 2) / 3);
    localparam logic [W-1:0] LO = W'(DB_CYC / 3);

    logic sync1_ff;
    logic sync2_ff;
    logic [W-1:0] integ_ff;
    logic [W-1:0] nxt_integ;
    logic level_ff;
    logic nxt_level;

    // the integrator plays the rc filter; it saturates so a held switch does not wrap
    assign nxt_integ = (sync2_ff && integ_ff != TOP) ? integ_ff + W'(1) :
                       (!sync2_ff && integ_ff != '0) ? integ_ff - W'(1) : integ_ff; // RULE9
    // one-third wide window between thresholds: bounce inside it cannot toggle the level
    assign nxt_level = (integ_ff >= HI) ? 1'b1 : (integ_ff <= LO) ? 1'b0 : level_ff; // RULE9
    assign level_o = level_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            integ_ff <= '0;
            level_ff <= 1'b0;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            integ_ff <= nxt_integ;
            level_ff <= nxt_level;
        end
    end

    property p_db_rise;
        @(posedge clk_i) disable iff (rst_i) $rose(level_ff) |-> $past(integ_ff) >= HI;
    endproperty
    a_db_rise: assert property (p_db_rise) else $error("debounce rose below upper threshold"); // RULE9

    property p_db_fall;
        @(posedge clk_i) disable iff (rst_i) $fell(level_ff) |-> $past(integ_ff) <= LO;
    endproperty
    a_db_fall: assert property (p_db_fall) else $error("debounce fell above lower threshold"); // RULE9
endmodule // psc_debounce
`default_nettype wire

// ===== sim/psc_panel_model.sv
// front panel contact model and shifter line monitor
`default_nettype none
module psc_panel_model
    import psc_pkg::*;
(
    // clock
    input wire logic clk_i,
    // operator actions: 1 holds phase up, 2 holds phase down, 3 closes both contacts
    input wire logic [1:0] hold_i,
    input wire logic bounce_i,
    // shifter lines from the block
    input wire psc_shifter_t shifter_a_i,
    input wire psc_shifter_t shifter_b_i,
    // contacts and decoded view
    output logic adjust_up_o,
    output logic adjust_down_o,
    output logic [5:0] word_o,
    output logic lines_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] chatter_ff;
    initial chatter_ff = 2'd0;
    // contact closes one cycle in three; an odd period walks across the step ticks
    always @(posedge clk_i) begin
        chatter_ff <= (!bounce_i || chatter_ff == 2'd2) ? 2'd0 : chatter_ff + 2'd1;
    end
    assign adjust_up_o = (hold_i == 2'd1) || (hold_i == 2'd3) || (bounce_i && chatter_ff == 2'd0);
    assign adjust_down_o = (hold_i == 2'd2) || (hold_i == 2'd3);
    assign word_o = shifter_a_i.grp_lo;
    // both groups equal and the second shifter the inverse of the first
    assign lines_ok_o = (shifter_a_i.grp_hi == shifter_a_i.grp_lo) && (shifter_b_i == ~shifter_a_i);
endmodule // psc_panel_model
`default_nettype wire

// ===== sim/testbench.sv
// self-checking testbench for the phase step counter control block
`include "psc_consts.svh"
`default_nettype none
module testbench
    import psc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned STEP = 16;
    logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, up, dn, lamp, irq, bounce, ok, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [3:0] sel;
    logic [1:0] hold;
    logic [5:0] word, w0, w1;
    psc_shifter_t sa, sb;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int n;

    psc_phase_ctl #(.STEP_CYC(STEP), .DB_CYC(6)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .adjust_up_i(up), .adjust_down_i(dn), .preset_selector_i(sel), .range_limit_indicator_o(lamp),
        .shifter_a_o(sa), .shifter_b_o(sb), .irq_o(irq)
    );
    psc_panel_model panel_u (
        .clk_i(clk_i), .hold_i(hold), .bounce_i(bounce), .shifter_a_i(sa), .shifter_b_i(sb),
        .adjust_up_o(up), .adjust_down_o(dn), .word_o(word), .lines_ok_o(ok)
    );

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic results();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the run is well under a thousand cycles; this only cuts a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // waits for the shifter word to move; n counts the cycles taken
    task automatic step();
        w0 = word;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (word === w0 && n < 200);
        // back onto the rising edge so the next stimulus is driven there
        @(posedge clk_i);
    endtask

    task automatic restart(input logic [3:0] s);
        @(posedge clk_i);
        hold <= 2'd0;
        sel <= s;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hold = 2'd0;
        bounce = 1'b0;
        sel = 4'h5;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rd(`PSC_ADDR_CTRL);
        check("ctrl", rq, 32'h1);
        rd(`PSC_ADDR_INT_MASK);
        check("int_mask", rq, 32'h0);
        rd(`PSC_ADDR_STATUS);
        check("status", rq, 32'h814);
        check("shifter_a", 32'(sa), 32'h514);
        check("shifter_b", 32'(sb), 32'haeb);
        rd(8'h10);
        check("unmapped_err", 32'(rerr), 32'h1);
        check("unmapped_data", rq, 32'h0);
        check("pready", 32'(pready), 32'h1);
        wr(`PSC_ADDR_STATUS, 32'h0);
        rd(`PSC_ADDR_STATUS);
        check("status_ro", rq, 32'h814);
        $display("test reset_and_bus done");

        wr(`PSC_ADDR_INT_MASK, 32'h3);
        hold <= 2'd1;
        step();
        check("up_first", 32'(word), 32'h15);
        step();
        check("step_gap", 32'(n), STEP);
        check("up_second", 32'(word), 32'h16);
        check("lines", 32'(ok), 32'h1);
        check("irq_step", 32'(irq), 32'h1);
        hold <= 2'd0;
        repeat (2 * STEP) @(posedge clk_i);
        wr(`PSC_ADDR_INT_STAT, 32'h3);
        rd(`PSC_ADDR_INT_STAT);
        check("int_clear", rq, 32'h0);
        check("irq_clear", 32'(irq), 32'h0);
        $display("test step_up done");

        // a masked event must stay off the interrupt line
        wr(`PSC_ADDR_INT_MASK, 32'h0);
        w1 = word;
        hold <= 2'd2;
        step();
        check("down", 32'(word), 32'(w1 - 6'd1));
        check("lines_down", 32'(ok), 32'h1);
        check("irq_masked", 32'(irq), 32'h0);
        rd(`PSC_ADDR_INT_STAT);
        check("int_sticky", rq & 32'h1, 32'h1);
        hold <= 2'd0;
        repeat (2 * STEP) @(posedge clk_i);
        wr(`PSC_ADDR_INT_STAT, 32'h3);
        $display("test step_down done");

        wr(`PSC_ADDR_CTRL, 32'h0);
        w1 = word;
        hold <= 2'd1;
        repeat (3 * STEP) @(posedge clk_i);
        check("standby_hold", 32'(word), 32'(w1));
        rd(`PSC_ADDR_STATUS);
        check("standby_flag", rq & 32'h800, 32'h0);
        wr(`PSC_ADDR_CTRL, 32'h1);
        step();
        check("operate_step", 32'(word), 32'(w1 + 6'd1));
        hold <= 2'd0;
        repeat (2 * STEP) @(posedge clk_i);
        $display("test operate done");

        w1 = word;
        bounce <= 1'b1;
        repeat (3 * STEP) @(posedge clk_i);
        check("chatter", 32'(word), 32'(w1));
        bounce <= 1'b0;
        repeat (STEP) @(posedge clk_i);
        hold <= 2'd3;
        repeat (3 * STEP) @(posedge clk_i);
        check("both_contacts", 32'(word), 32'(w1));
        $display("test debounce done");

        restart(4'hf);
        hold <= 2'd1;
        repeat (3) step();
        check("top", 32'(word), 32'h3f);
        repeat (3 * STEP) @(posedge clk_i);
        check("top_hold", 32'(word), 32'h3f);
        check("lamp_top", 32'(lamp), 32'h1);
        check("max_lines", 32'(sa), 32'hfff);
        check("max_inv", 32'(sb), 32'h0);
        rd(`PSC_ADDR_STATUS);
        check("status_lamp", rq & 32'h100, 32'h100);
        rd(`PSC_ADDR_INT_STAT);
        check("limit_event", rq & 32'h2, 32'h2);
        hold <= 2'd2;
        step();
        check("leave_top", 32'(word), 32'h3e);
        check("lamp_off", 32'(lamp), 32'h0);
        restart(4'h0);
        hold <= 2'd2;
        repeat (4 * STEP) @(posedge clk_i);
        check("bottom_hold", 32'(word), 32'h0);
        check("lamp_bottom", 32'(lamp), 32'h1);
        check("min_lines", 32'(sa), 32'h0);
        $display("test limits done");
        results();
    end
endmodule // testbench
`default_nettype wire
